/* File: src/bipu_pkg.sv */
// package of the board interrupt priority unit: commands, modes, offsets
// assumes both ends and the bench import it whole
package bipu_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NSRC = 18;  // jumper-selectable sources
  localparam int NLVL = 8;   // request levels of the unit
  localparam int SELW = 5;   // width of one jumper select

  // source numbers seen on the jumper selects; values 18..31 mean open
  localparam logic [4:0] SRC_PAR_IN_FULL  = 5'h00;
  localparam logic [4:0] SRC_PAR_OUT_EMPT = 5'h01;
  localparam logic [4:0] SRC_SER_RX_RDY   = 5'h02;
  localparam logic [4:0] SRC_SER_TX_EMPT  = 5'h03;
  localparam logic [4:0] SRC_TIMER0       = 5'h04;
  localparam logic [4:0] SRC_TIMER1       = 5'h05;
  localparam logic [4:0] SRC_BUS_VEC0     = 5'h06;  // bus_vectored 0..7 at 06..0d
  localparam logic [4:0] SRC_PERIPH       = 5'h0e;
  localparam logic [4:0] SRC_POWER_FAIL   = 5'h0f;
  localparam logic [4:0] SRC_OPEN         = 5'h12;  // first value that routes nothing

  // ----------------------------------------------------------------
  // modes and commands
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {MD_NESTED, MD_FULLY, MD_ROTATE, MD_SPECIFIC, MD_SMASK} bipu_mode_t;

  localparam logic [3:0] CMD_MODE   = 4'h1;  // arg[2:0] mode
  localparam logic [3:0] CMD_MASK   = 4'h2;  // arg = per-level mask, 1 blocks
  localparam logic [3:0] CMD_TRIG   = 4'h3;  // arg = per-level trigger, 1 edge, 0 level
  localparam logic [3:0] CMD_LOWEST = 4'h4;  // arg[2:0] lowest level, specific mode
  localparam logic [3:0] CMD_BASE   = 4'h5;  // arg[7:3] identifier base
  localparam logic [3:0] CMD_CASC   = 4'h6;  // arg = levels that carry a slave unit
  localparam logic [3:0] CMD_EOI    = 4'h7;  // end of service, highest level in service
  localparam logic [3:0] CMD_POLL   = 4'h8;  // poll, answered with found bit and level

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_MASK   = 8'hff;
  localparam logic [7:0] RST_TRIG   = 8'h00;
  localparam logic [2:0] RST_LOWEST = 3'h7;
  localparam logic [4:0] RST_BASE   = 5'h00;
  localparam int         POLL_FOUND = 7;     // bit of a poll answer

  // ----------------------------------------------------------------
  // processor-side register map and fields
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL   = 4'h0;  // [0] maskable_request enable, [1] poll mode
  localparam logic [3:0] ADDR_CMD    = 4'h1;  // write [11:8] code, [7:0] arg
  localparam logic [3:0] ADDR_STATUS = 4'h2;  // sticky, write one to clear
  localparam logic [3:0] ADDR_IMASK  = 4'h3;
  localparam logic [3:0] ADDR_ID     = 4'h4;  // last identifier
  localparam logic [3:0] ADDR_VECTOR = 4'h5;  // last vector address
  localparam logic [3:0] ADDR_POLL   = 4'h6;  // last poll answer
  localparam int CTRL_IEN = 0;
  localparam int CTRL_POLL = 1;
  localparam int ST_VEC = 0;
  localparam int ST_POLL = 1;
  localparam int ST_NMI = 2;
  localparam int ST_SLV = 3;
  localparam int NST = 4;
  localparam logic [15:0] NMI_VECTOR = 16'h0008;

endpackage

/* File: src/bipu_if.sv */
// link between the priority unit and the processor-side controller
// assumes one clock shared by both ends; the bench joins the two modports
`timescale 1ns/1ps
`default_nettype none

interface bipu_if;
  import bipu_pkg::*;
  logic       maskable_request;  // unit -> cpu, level
  logic       ack;               // cpu -> unit, one-cycle pulse
  logic       ans_valid;         // unit -> cpu, one-cycle pulse
  logic [7:0] ans_data;          // identifier or poll answer
  logic       cmd_valid;         // cpu -> unit, one-cycle pulse
  logic [3:0] cmd_code;
  logic [7:0] cmd_arg;

  modport dev (input ack, cmd_valid, cmd_code, cmd_arg,
               output maskable_request, ans_valid, ans_data);
  modport cpu (output ack, cmd_valid, cmd_code, cmd_arg,
               input maskable_request, ans_valid, ans_data);
endinterface

`default_nettype wire

/* File: src/bipu_priority_request_unit.sv */
// priority_request_unit: routes 18 sources onto 8 levels and resolves them
// assumes a processor-side end on bipu_if and slave units on slave_id_i
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module bipu_priority_request_unit
  import bipu_pkg::*;
(
  input  wire logic                       mclk_i,
  input  wire logic                       rst_b_i,
  input  wire logic                       ce_i,
  input  wire logic [NSRC-1:0]            src_i,
  input  wire logic [NLVL-1:0][SELW-1:0]  jumper_i,
  input  wire logic [7:0]                 slave_id_i,
  output logic      [2:0]                 casc_sel_o,
  bipu_if.dev                             link
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NSRC-1:0] s1, s2, s3, flt;
    logic [7:0]      prev, irr, isr, imr, trig, casc;
    bipu_mode_t      mode;
    logic [2:0]      lowest, last, win;
    logic [4:0]      base;
    logic            mreq, ans_valid;
    logic [7:0]      ans_data;
  } bipu_dev_st_t;

  bipu_dev_st_t q_ff, nxt_q;
  logic [7:0]   req;

  // first set bit walking up from start, wrapping; {found, level}
  function automatic logic [3:0] first_set(input logic [7:0] v, input logic [2:0] start);
    logic [3:0] r;
    logic [2:0] l;
    r = 4'h0;
    for (int i = 7; i >= 0; i--)
    begin
      l = start + 3'(i);
      if (v[l])
        r = {1'b1, l};
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // jumper routing
  // ----------------------------------------------------------------
  // parallel, serial, counters, bus lines, all 18
  for (genvar g = 0; g < NLVL; g++)
  begin : g_route
    assign req[g] = (jumper_i[g] < SRC_OPEN) ? q_ff.flt[jumper_i[g]] : 1'b0;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // priority start, candidates and blocking, all from registered state
  logic [2:0] start, cand, top, lvl;
  logic [3:0] fc, ft;
  logic [7:0] elig;
  logic       allow, take;
  always_comb
  begin
    nxt_q = q_ff;
    lvl   = 3'h0;
    take  = 1'b0;
    // source pins: three flops, accepted when the last two agree
    nxt_q.s1 = src_i;
    nxt_q.s2 = q_ff.s1;
    nxt_q.s3 = q_ff.s2;
    for (int i = 0; i < NSRC; i++)
    begin
      if (q_ff.s2[i] == q_ff.s3[i])
        nxt_q.flt[i] = q_ff.s3[i];
    end
    nxt_q.prev = req;
    // edge levels latch a rising edge, level levels follow the line
    for (int i = 0; i < NLVL; i++)
    begin
      if (q_ff.trig[i])
        nxt_q.irr[i] = q_ff.irr[i] | (req[i] & ~q_ff.prev[i]);
      else
        nxt_q.irr[i] = req[i];
    end
    // nested orders start at 0; rotate after last; after lowest
    case (q_ff.mode)
      MD_ROTATE:   start = q_ff.last + 3'h1;
      MD_SPECIFIC: start = q_ff.lowest + 3'h1;
      default:     start = 3'h0;
    endcase
    // special mask drops only levels in service
    elig = q_ff.irr & ~q_ff.imr & ((q_ff.mode == MD_SMASK) ? ~q_ff.isr : 8'hff);
    fc   = first_set(elig, start);
    ft   = first_set(q_ff.isr, start);
    cand = fc[2:0];
    top  = ft[2:0];
    // outside special mask, a candidate must outrank the highest level in service
    if (q_ff.mode == MD_SMASK)
      allow = fc[3];
    else
      allow = fc[3] && (!ft[3] || ((cand - start) < (top - start))
            // in fully nested mode a cascaded level in service stays open to its slave
            || (q_ff.mode == MD_FULLY && cand == top && q_ff.casc[cand]));
    // request held until acknowledged, then re-evaluated
    nxt_q.ans_valid = 1'b0;
    if (!q_ff.mreq)
    begin
      // one combined request toward the cpu
      nxt_q.mreq = allow;
      nxt_q.win  = cand;
    end
    // acknowledge answered with the winner's identifier
    if (link.ack && q_ff.mreq)
    begin
      take = 1'b1;
      lvl  = q_ff.win;
      nxt_q.mreq      = 1'b0;
      nxt_q.ans_valid = 1'b1;
      // a cascaded level takes its identifier from the slave
      nxt_q.ans_data  = q_ff.casc[lvl] ? slave_id_i : {q_ff.base, lvl};
    end
    // commands
    if (link.cmd_valid)
    begin
      case (link.cmd_code)
        CMD_MODE:   nxt_q.mode   = bipu_mode_t'(link.cmd_arg[2:0]);
        CMD_MASK:   nxt_q.imr    = link.cmd_arg;
        CMD_TRIG:   nxt_q.trig   = link.cmd_arg;
        CMD_LOWEST: nxt_q.lowest = link.cmd_arg[2:0];
        CMD_BASE:   nxt_q.base   = link.cmd_arg[7:3];
        CMD_CASC:   nxt_q.casc   = link.cmd_arg;
        CMD_EOI:
        begin
          if (ft[3])
          begin
            nxt_q.isr[top] = 1'b0;
            // serviced level drops to lowest until the next one
            if (q_ff.mode == MD_ROTATE)
              nxt_q.last = top;
          end
        end
        CMD_POLL:
        begin
          // poll answered with found flag and level; a hit is serviced
          if (!take)
          begin
            nxt_q.ans_valid = 1'b1;
            nxt_q.ans_data  = {allow, 4'h0, cand};
            if (allow)
            begin
              take = 1'b1;
              lvl  = cand;
              nxt_q.mreq = 1'b0;
            end
          end
        end
        default: ;
      endcase
    end
    // servicing moves a level into service; an edge request is consumed
    if (take)
    begin
      nxt_q.isr[lvl] = 1'b1;
      if (q_ff.trig[lvl])
        nxt_q.irr[lvl] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // reset masks every level so nothing fires before software sets up
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      q_ff        <= '0;
      q_ff.imr    <= RST_MASK;
      q_ff.trig   <= RST_TRIG;
      q_ff.mode   <= MD_NESTED;
      q_ff.lowest <= RST_LOWEST;
      q_ff.last   <= RST_LOWEST;
      q_ff.base   <= RST_BASE;
    end
    else if (ce_i)
      q_ff <= nxt_q;
  end

  assign link.maskable_request = q_ff.mreq;
  assign link.ans_valid        = q_ff.ans_valid;
  assign link.ans_data         = q_ff.ans_data;
  assign casc_sel_o            = q_ff.win;

endmodule // bipu_priority_request_unit

`default_nettype wire

/* File: src/bipu_cpu_ctrl.sv */
// processor-side controller: takes the combined request, fetches identifiers
// assumes software on a plain register port and the unit on bipu_if
`timescale 1ns/1ps
`default_nettype none

module bipu_cpu_ctrl
  import bipu_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  input  wire logic        ce_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  output logic             irq_o,
  input  wire logic        nmi_i,
  input  wire logic        slave_pend_i,
  bipu_if.cpu              link
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {HS_IDLE, HS_ACK, HS_POLL} bipu_hs_t;
  typedef struct packed {
    bipu_hs_t        fsm;
    logic [1:0]      ctrl;
    logic [NST-1:0]  status, imask;
    logic [7:0]      id, poll;
    logic [15:0]     vec, rdata;
    logic            n1, n2, n3, nflt;
    logic            ack, cmd_valid;
    logic [3:0]      code;
    logic [7:0]      arg;
  } bipu_cpu_st_t;

  bipu_cpu_st_t q_ff, nxt_q;
  logic [NST-1:0] set, clr;
  logic           wcmd;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_q = q_ff;
    set   = '0;
    clr   = '0;
    wcmd  = wr_i && addr_i == ADDR_CMD;
    nxt_q.ack       = 1'b0;
    nxt_q.cmd_valid = 1'b0;
    // nmi pin: three flops, accepted once the last two agree
    nxt_q.n1 = nmi_i;
    nxt_q.n2 = q_ff.n1;
    nxt_q.n3 = q_ff.n2;
    if (q_ff.n2 == q_ff.n3)
      nxt_q.nflt = q_ff.n3;
    // nmi bypasses the unit and vectors to a fixed address unless an identifier arrives in the same cycle
    if (nxt_q.nflt && !q_ff.nflt)
    begin
      set[ST_NMI] = 1'b1;
      nxt_q.vec   = NMI_VECTOR;
    end
    // software writes
    if (wr_i && addr_i == ADDR_CTRL)
      nxt_q.ctrl = wdata_i[1:0];
    if (wr_i && addr_i == ADDR_IMASK)
      nxt_q.imask = wdata_i[NST-1:0];
    if (wr_i && addr_i == ADDR_STATUS)
      clr = wdata_i[NST-1:0];
    // commands; a poll outside idle is dropped
    if (wcmd)
    begin
      nxt_q.code = wdata_i[11:8];
      nxt_q.arg  = wdata_i[7:0];
      nxt_q.cmd_valid = 1'b1;
      // a pending slave holds back the end of service
      if (wdata_i[11:8] == CMD_EOI && slave_pend_i)
      begin
        nxt_q.cmd_valid = 1'b0;
        set[ST_SLV]     = 1'b1;
      end
      if (wdata_i[11:8] == CMD_POLL)
      begin
        nxt_q.cmd_valid = (q_ff.fsm == HS_IDLE);
        if (q_ff.fsm == HS_IDLE)
          nxt_q.fsm = HS_POLL;
      end
    end
    case (q_ff.fsm)
      HS_IDLE:
      begin
        // in poll mode the request input stays ignored
        if (link.maskable_request && q_ff.ctrl[CTRL_IEN] && !q_ff.ctrl[CTRL_POLL]
            && !wcmd && !q_ff.cmd_valid)
        begin
          nxt_q.ack = 1'b1;
          nxt_q.fsm = HS_ACK;
        end
      end
      HS_ACK:
      begin
        if (link.ans_valid)
        begin
          nxt_q.id    = link.ans_data;
          // vector address is the identifier times four
          nxt_q.vec   = {6'h00, link.ans_data, 2'b00};
          set[ST_VEC] = 1'b1;
          nxt_q.fsm   = HS_IDLE;
        end
      end
      HS_POLL:
      begin
        if (link.ans_valid)
        begin
          nxt_q.poll   = link.ans_data;
          set[ST_POLL] = 1'b1;
          nxt_q.fsm    = HS_IDLE;
        end
      end
      default: nxt_q.fsm = HS_IDLE;
    endcase
    // a set in the same cycle as its clear wins
    nxt_q.status = (q_ff.status & ~clr) | set;
    // read data stands the cycle after the strobe only
    nxt_q.rdata = '0;
    if (rd_i)
    begin
      case (addr_i)
        ADDR_CTRL:   nxt_q.rdata = {14'h0000, q_ff.ctrl};
        ADDR_STATUS: nxt_q.rdata = {12'h000, q_ff.status};
        ADDR_IMASK:  nxt_q.rdata = {12'h000, q_ff.imask};
        ADDR_ID:     nxt_q.rdata = {8'h00, q_ff.id};
        ADDR_VECTOR: nxt_q.rdata = q_ff.vec;
        ADDR_POLL:   nxt_q.rdata = {8'h00, q_ff.poll};
        default:     nxt_q.rdata = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      q_ff     <= '0;
      q_ff.fsm <= HS_IDLE;
    end
    else if (ce_i)
      q_ff <= nxt_q;
  end

  assign rdata_o        = q_ff.rdata;
  assign irq_o          = |(q_ff.status & q_ff.imask);
  assign link.ack       = q_ff.ack;
  assign link.cmd_valid = q_ff.cmd_valid;
  assign link.cmd_code  = q_ff.code;
  assign link.cmd_arg   = q_ff.arg;

endmodule // bipu_cpu_ctrl

`default_nettype wire

/* File: verif/bipu_props.sv */
// link checker of the board interrupt priority unit
// assumes the bench hands it every signal of the link between the two ends
`timescale 1ns/1ps
`default_nettype none

module bipu_props
  import bipu_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  input  wire logic       maskable_request,
  input  wire logic       ack,
  input  wire logic       ans_valid,
  input  wire logic [7:0] ans_data,
  input  wire logic       cmd_valid,
  input  wire logic [3:0] cmd_code,
  input  wire logic [7:0] cmd_arg
);
  // ----------------------------------------------------------------
  // steps of a transfer
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  // an acknowledge only counts while the request stands
  sequence s_ack_taken;
    ack && maskable_request;
  endsequence

  // a poll in the same cycle as an acknowledge is dropped
  sequence s_poll_cmd;
    cmd_valid && cmd_code == CMD_POLL && !ack;
  endsequence

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_ack_answer: assert property (s_ack_taken |=> ans_valid)
    else $error("no answer one cycle after acknowledge");
  a_req_drops: assert property (s_ack_taken |=> !maskable_request)
    else $error("request still up after acknowledge");
  // a command may legally change what is pending, so it is left out
  a_req_holds: assert property (maskable_request && !ack && !cmd_valid |=> maskable_request)
    else $error("request dropped before acknowledge");
  a_ack_gated: assert property (ack |-> maskable_request)
    else $error("acknowledge without a request");
  a_poll_answer: assert property (s_poll_cmd |=> ans_valid)
    else $error("poll left unanswered");
  a_poll_format: assert property (s_poll_cmd ##1 ans_valid |-> ans_data[6:3] == 4'h0)
    else $error("poll answer has stray bits");
  a_ans_cause: assert property ($rose(ans_valid) |->
      $past(ack && maskable_request) || $past(cmd_valid && cmd_code == CMD_POLL))
    else $error("answer without acknowledge or poll");
  a_ans_pulse: assert property (ans_valid |=> !ans_valid)
    else $error("answer longer than one cycle");
  a_data_holds: assert property (!ans_valid |-> $stable(ans_data))
    else $error("answer data moved outside an answer");
  a_ack_pulse: assert property (ack |=> !ack)
    else $error("acknowledge longer than one cycle");
endmodule // bipu_props

`default_nettype wire

/* File: verif/board_interrupt_priority_unit_tb.sv */
// testbench of the board interrupt priority unit: both ends joined on one link
// assumes bipu_pkg, bipu_if and both ends compiled first; one 25 MHz clock
`timescale 1ns/1ps
`default_nettype none

module board_interrupt_priority_unit_tb;
  import bipu_pkg::*;
  logic                      mclk_i  = 1'b0;
  logic                      rst_b_i = 1'b0;
  logic [NSRC-1:0]           src     = '0;
  logic [NLVL-1:0][SELW-1:0] jmp     = {NLVL{SRC_OPEN}};
  logic                      ce      = 1'b1;
  logic [2:0]                csel;
  logic [7:0]                sid;
  logic [3:0]                addr    = 4'h0;
  logic [15:0]               wdata   = 16'h0000;
  logic                      wr_s    = 1'b0;
  logic                      rd_s    = 1'b0;
  logic                      nmi     = 1'b0;
  logic                      spend   = 1'b0;
  logic [15:0]               rdata;
  logic                      irq;
  int                        miscompares = 0;
  int                        samples_checked = 0;

  bipu_if link ();

  always #20 mclk_i = ~mclk_i;

  // slave identifier follows the level the master selects, so a wrong select shows
  assign sid = {5'h0b, csel};

  // ----------------------------------------------------------------
  // both ends and the link checker
  // ----------------------------------------------------------------
  bipu_priority_request_unit i_bipu_priority_request_unit (.mclk_i(mclk_i),
    .rst_b_i(rst_b_i), .ce_i(ce), .src_i(src), .jumper_i(jmp), .slave_id_i(sid),
    .casc_sel_o(csel), .link(link.dev));
  bipu_cpu_ctrl i_bipu_cpu_ctrl (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata),
    .irq_o(irq), .nmi_i(nmi), .slave_pend_i(spend), .link(link.cpu));
  bipu_props i_bipu_props (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .maskable_request(link.maskable_request), .ack(link.ack),
    .ans_valid(link.ans_valid), .ans_data(link.ans_data), .cmd_valid(link.cmd_valid),
    .cmd_code(link.cmd_code), .cmd_arg(link.cmd_arg));

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge mclk_i);
    wr_s  <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge mclk_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk_i);
    rd_s <= 1'b0;
    #1;
    chk(rdata, e);
  endtask

  task automatic cmd(input logic [3:0] c, input logic [7:0] a);
    wr(ADDR_CMD, {4'h0, c, a});
  endtask

  // waits for the fetched identifier, checks it, clears the status
  task automatic svc(input logic [7:0] exp);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 300)
    begin
      tick(1);
      n++;
    end
    // a request that never arrives counts, not only a wrong identifier
    chk({15'h0000, irq}, 16'h0001);
    rd_chk(ADDR_ID, {8'h00, exp});
    wr(ADDR_STATUS, 16'h000f);
  endtask

  // lets a dropped line clear the synchroniser before ending service
  task automatic eoi;
    tick(6);
    cmd(CMD_EOI, 8'h00);
  endtask

  // levels 0..6 are jumpered to the bus lines
  task automatic set_lv(input logic [7:0] m);
    @(posedge mclk_i);
    src[12:6] <= m[6:0];
  endtask

  task automatic end_sim;
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // a hang counts as a mismatch
  initial
  begin
    tick(20000);
    miscompares++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    tick(5);
    rst_b_i <= 1'b1;
    rd_chk(ADDR_STATUS, 16'h0000);
    rd_chk(4'hf, 16'h0000);
    wr(ADDR_CTRL, 16'h0001);
    wr(ADDR_IMASK, 16'h0001);
    cmd(CMD_MASK, 8'h00);
    cmd(CMD_BASE, 8'h80);
    // every source through the jumper of level 7
    for (int s = 0; s < NSRC; s++)
    begin
      @(posedge mclk_i);
      jmp[7] <= s[4:0];
      src[s] <= 1'b1;
      svc(8'h87);
      src[s] <= 1'b0;
      eoi();
    end
    // identifier scaled by four
    rd_chk(ADDR_VECTOR, 16'h021c);
    @(posedge mclk_i);
    for (int l = 0; l < 7; l++)
      jmp[l] <= SRC_BUS_VEC0 + l[4:0];
    jmp[7] <= SRC_OPEN;
    // fixed order: 3 before 5
    set_lv(8'h28);
    svc(8'h83);
    set_lv(8'h20);
    eoi();
    svc(8'h85);
    set_lv(8'h00);
    eoi();
    // rotation: a serviced level still requesting goes last
    cmd(CMD_MODE, 8'h02);
    set_lv(8'h06);
    svc(8'h81);
    eoi();
    svc(8'h82);
    eoi();
    svc(8'h81);
    set_lv(8'h00);
    eoi();
    // lowest named 4, so 6 ranks above 2
    cmd(CMD_MODE, 8'h03);
    cmd(CMD_LOWEST, 8'h04);
    set_lv(8'h44);
    svc(8'h86);
    set_lv(8'h04);
    eoi();
    svc(8'h82);
    set_lv(8'h00);
    eoi();
    // special mask: lower level served, in-service level blocked
    cmd(CMD_MODE, 8'h04);
    set_lv(8'h20);
    svc(8'h85);
    set_lv(8'h60);
    svc(8'h86);
    tick(8);
    rd_chk(ADDR_STATUS, 16'h0000);
    set_lv(8'h00);
    eoi();
    eoi();
    // edge trigger keeps a pulse that is gone by service time
    cmd(CMD_MODE, 8'h00);
    cmd(CMD_TRIG, 8'h08);
    wr(ADDR_CTRL, 16'h0000);
    set_lv(8'h08);
    tick(8);
    set_lv(8'h00);
    tick(8);
    wr(ADDR_CTRL, 16'h0001);
    svc(8'h83);
    eoi();
    // poll with the interrupt input off
    wr(ADDR_CTRL, 16'h0002);
    set_lv(8'h10);
    tick(6);
    cmd(CMD_POLL, 8'h00);
    tick(4);
    rd_chk(ADDR_POLL, 16'h0084);
    set_lv(8'h00);
    eoi();
    wr(ADDR_CTRL, 16'h0001);
    // cascaded slave at level 1 accepted again while in service
    cmd(CMD_MODE, 8'h01);
    cmd(CMD_TRIG, 8'h02);
    cmd(CMD_CASC, 8'h02);
    for (int k = 0; k < 2; k++)
    begin
      set_lv(8'h02);
      tick(8);
      set_lv(8'h00);
      svc(8'h59);
    end
    // end of service held back while the slave still has work
    @(posedge mclk_i);
    spend <= 1'b1;
    eoi();
    tick(4);
    rd_chk(ADDR_STATUS, 16'h0008);
    @(posedge mclk_i);
    spend <= 1'b0;
    wr(ADDR_STATUS, 16'h000f);
    eoi();
    eoi();
    // non-maskable event: fixed vector, masked then unmasked
    @(posedge mclk_i);
    nmi <= 1'b1;
    tick(8);
    nmi <= 1'b0;
    tick(4);
    chk({15'h0000, irq}, 16'h0000);
    rd_chk(ADDR_VECTOR, NMI_VECTOR);
    rd_chk(ADDR_STATUS, 16'h0004);
    wr(ADDR_IMASK, 16'h0004);
    tick(2);
    chk({15'h0000, irq}, 16'h0001);
    wr(ADDR_STATUS, 16'h0004);
    tick(2);
    chk({15'h0000, irq}, 16'h0000);
    // clock enable low: a write in that time is not taken
    @(posedge mclk_i);
    ce <= 1'b0;
    wr(ADDR_IMASK, 16'h0000);
    @(posedge mclk_i);
    ce <= 1'b1;
    rd_chk(ADDR_IMASK, 16'h0004); // clock enable hold
    end_sim();
  end
endmodule // board_interrupt_priority_unit_tb

`default_nettype wire
